// file: awg_top.sv
// The register addresses and register access over AHB-Lite are this design's own decisions.
`include "awg_regs.svh"
`default_nettype none
module awg_top
	import awg_pkg::*;
#(
	parameter int NPINS = `AWG_NPINS,
	parameter int CNT_W = `AWG_CNT_W
)(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [NPINS-1:0] pin_i,
	output logic [NPINS-1:0] pin_o,
	output logic [NPINS-1:0] pin_oe_o,
	output logic port_clk_en_o,
	output logic irq_o
);
	logic wr_pend_q;
	logic [11:0] wr_addr_q;
	logic [11:0] rd_addr_q;
	logic ctrl_q;
	logic [NPINS-1:0] dout_q;
	logic [NPINS-1:0] dir_q;
	logic [NPINS-1:0] wen_q;
	logic [NPINS-1:0] stat_q;
	logic [NPINS-1:0] mask_q;
	logic [NPINS-1:0] run_q;
	logic [NPINS-1:0] restart_q;
	logic [NPINS-1:0] sync1_q;
	logic [NPINS-1:0] sync2_q;
	logic [NPINS-1:0] pin_q;
	logic [NPINS-1:0] oe_q;
	logic [NPINS-1:0] wave_w;
	logic [NPINS-1:0] wrap_w;
	logic [CNT_W-1:0] per_q [NPINS];
	logic [CNT_W-1:0] hi_q [NPINS];
	logic [31:0] rdata_q;
	wire addr_ok_w = hsel_i && hready_i && htrans_i[1];
	wire wr_take_w = addr_ok_w && hwrite_i;
	wire rd_take_w = addr_ok_w && !hwrite_i;
	wire wr_ctrl_w = wr_pend_q && wr_addr_q == `AWG_OFF_CTRL;
	wire wr_dout_w = wr_pend_q && wr_addr_q == `AWG_OFF_DOUT;
	wire wr_dir_w = wr_pend_q && wr_addr_q == `AWG_OFF_DIR;
	wire wr_wen_w = wr_pend_q && wr_addr_q == `AWG_OFF_WEN;
	wire wr_stat_w = wr_pend_q && wr_addr_q == `AWG_OFF_STAT;
	wire wr_mask_w = wr_pend_q && wr_addr_q == `AWG_OFF_MASK;
	wire wr_cmd_w = wr_pend_q && wr_addr_q == `AWG_OFF_CMD;
	wire wr_chan_w = wr_pend_q && wr_addr_q >= `AWG_OFF_CH_BASE &&
		wr_addr_q < `AWG_OFF_CH_BASE + 12'(NPINS * 8);
	wire [11:0] ch_off_w = wr_addr_q - `AWG_OFF_CH_BASE;
	wire [2:0] ch_idx_w = ch_off_w[`AWG_CH_STRIDE_LSB +: 3];
	wire ch_hi_sel_w = ch_off_w[2];
	wire [NPINS-1:0] wdata_w = hwdata_i[NPINS-1:0];
	wire start_w = wr_cmd_w && hwdata_i[`AWG_CMD_START];
	wire stop_w = wr_cmd_w && hwdata_i[`AWG_CMD_STOP];
	wire [NPINS-1:0] cmd_sel_w = hwdata_i[8 +: NPINS];
	wire [NPINS-1:0] pend_w = stat_q & mask_q;
	// Write phase is registered on the data phase; every access completes with no wait state.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			rd_addr_q <= '0;
		end
		else
		begin
			wr_pend_q <= wr_take_w;
			if (addr_ok_w)
				wr_addr_q <= haddr_i[11:0];
			if (rd_take_w)
				rd_addr_q <= haddr_i[11:0];
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ctrl_q <= 1'b0;
			dout_q <= '0;
			dir_q <= '0;
			wen_q <= '0;
			mask_q <= '0;
		end
		else
		begin
			if (wr_ctrl_w)
				ctrl_q <= hwdata_i[`AWG_CTRL_CLKEN]; // [RL2]
			if (wr_dout_w)
				dout_q <= wdata_w; // [RL4]
			if (wr_dir_w)
				dir_q <= wdata_w; // [RL8]
			if (wr_wen_w)
				wen_q <= wdata_w;
			if (wr_mask_w)
				mask_q <= wdata_w;
		end
	end
	// Start and stop apply to the channels chosen in bits 15:8 of the command word.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			run_q <= '0;
			restart_q <= '0;
		end
		else
		begin
			restart_q <= start_w ? cmd_sel_w : '0;
			if (stop_w)
				run_q <= run_q & ~cmd_sel_w; // [RL11]
			else if (start_w)
				run_q <= run_q | cmd_sel_w; // [RL5]
		end
	end
	// Hardware set wins over a write-one clear in the same cycle.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			stat_q <= '0;
		else
			stat_q <= (stat_q & ~(wr_stat_w ? wdata_w : '0)) | (wrap_w & run_q); // [RL7]
	end
	// The first stage feeds only the second one, keeping metastability off the read path.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= pin_i; // [RL10]
			sync2_q <= sync1_q; // [RL10]
		end
	end
	genvar g;
	generate
		for (g = 0; g < NPINS; g++)
		begin : gen_ch
			awg_chan_if #(.CNT_W(CNT_W)) cif ();
			assign cif.clk_en = ctrl_q;
			assign cif.run = run_q[g] && wen_q[g];
			assign cif.restart = restart_q[g];
			assign cif.period = per_q[g];
			assign cif.high = hi_q[g];
			assign wave_w[g] = cif.wave;
			assign wrap_w[g] = cif.wrap;
			awg_channel #(.CNT_W(CNT_W)) u_ch (
				.ref_clk_i(ref_clk_i),
				.arst_n_i(arst_n_i),
				.ch(cif.chan)
			);
			always_ff @(posedge ref_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					per_q[g] <= '0;
					hi_q[g] <= '0;
					pin_q[g] <= 1'b0;
					oe_q[g] <= 1'b0;
				end
				else
				begin
					if (wr_chan_w && ch_idx_w == 3'(g) && !ch_hi_sel_w)
						per_q[g] <= hwdata_i[CNT_W-1:0]; // [RL11]
					if (wr_chan_w && ch_idx_w == 3'(g) && ch_hi_sel_w)
						hi_q[g] <= hwdata_i[CNT_W-1:0]; // [RL11]
					pin_q[g] <= (wen_q[g] && run_q[g]) ? wave_w[g] : dout_q[g]; // [RL1] [RL3]
					oe_q[g] <= dir_q[g]; // [RL8]
				end
			end
		end
	endgenerate
	wire [31:0] din_w = {{(32-NPINS){1'b0}}, sync2_q}; // [RL9]
	wire [2:0] rd_idx_w = rd_addr_q[`AWG_CH_STRIDE_LSB +: 3];
	wire rd_chan_w = rd_addr_q >= `AWG_OFF_CH_BASE &&
		rd_addr_q < `AWG_OFF_CH_BASE + 12'(NPINS * 8);
	wire [CNT_W-1:0] rd_cnt_w = rd_addr_q[2] ? hi_q[rd_idx_w] : per_q[rd_idx_w];
	logic [31:0] rmux_w;
	always_comb
	begin
		rmux_w = 32'h0000_0000;
		case (rd_addr_q)
			`AWG_OFF_CTRL: rmux_w = {31'h0, ctrl_q};
			`AWG_OFF_DOUT: rmux_w = {{(32-NPINS){1'b0}}, dout_q};
			`AWG_OFF_DIR: rmux_w = {{(32-NPINS){1'b0}}, dir_q};
			`AWG_OFF_DIN: rmux_w = din_w;
			`AWG_OFF_WEN: rmux_w = {{(32-NPINS){1'b0}}, wen_q};
			`AWG_OFF_STAT: rmux_w = {{(32-NPINS){1'b0}}, stat_q};
			`AWG_OFF_MASK: rmux_w = {{(32-NPINS){1'b0}}, mask_q};
			`AWG_OFF_CMD: rmux_w = {{(24-NPINS){1'b0}}, run_q, 8'h00};
			default:
				if (rd_chan_w)
					rmux_w = {{(32-CNT_W){1'b0}}, rd_cnt_w};
		endcase
	end
	assign hrdata_o = rmux_w;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign pin_o = pin_q;
	assign pin_oe_o = oe_q;
	assign port_clk_en_o = ctrl_q; // [RL2]
	assign irq_o = |pend_w; // [RL7]
	a_dout_update: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		wr_dout_w && !run_q[0] |=> ##1 pin_o[0] == $past(hwdata_i[0], 2)) // [RL4]
		else $error("pin 0 did not follow data write");
	a_dir_follow: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		wr_dir_w |=> ##1 pin_oe_o == $past(wdata_w, 2)) else $error("direction lost"); // [RL8]
	a_sync_delay: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		##2 sync2_q == $past(pin_i, 2)) else $error("input mirror delay wrong"); // [RL10]
	a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		irq_o == |(stat_q & mask_q)) else $error("irq mismatch"); // [RL7]
	a_wrap_sticky: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(wrap_w[0] && run_q[0]) |=> stat_q[0]) else $error("event lost"); // [RL7]
	a_start_run: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		start_w && !stop_w |=> (run_q & $past(cmd_sel_w)) == $past(cmd_sel_w))
		else $error("start ignored"); // [RL5]
	a_stop_halt: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		stop_w |=> (run_q & $past(cmd_sel_w)) == '0) else $error("stop ignored"); // [RL11]
	a_gate_freeze: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		!ctrl_q && !restart_q[0] && run_q[0] && $stable(run_q[0]) && wen_q[0] &&
		$stable(wen_q[0]) |=> $stable(wave_w[0]))
		else $error("wave moved with clock gated"); // [RL2] [RL6]
endmodule
`default_nettype wire

// file: awg_regs.svh
// Overview of operation
// RL1: Eight individually controlled output pins, numbered zero to seven.
// RL2: Port logic has its own clock gate, switched off to save power.
// RL3: Outputs may toggle every clock cycle, half the master clock rate.
// RL4: A write to the output data register changes the pins right after it completes.
// RL5: Software programs the waveform descriptions first, then issues a start command.
// RL6: Once started, waveforms run by themselves without further writes.
// RL7: Selected waveform points raise an interrupt towards both processors; this design drives a single irq_o, set by the period wrap of masked channels.
// RL8: Each pin can be turned into a high-impedance input.
// RL9: A readable register mirrors every pin level continuously.
// RL10: Pin levels pass a two-flop synchroniser before the mirror register.
// RL11: Each channel has period and high-time counts, repeats until stopped, last write wins.
`ifndef AWG_REGS_SVH
`define AWG_REGS_SVH
`define AWG_NPINS 8
`define AWG_CNT_W 16
`define AWG_OFF_CTRL 12'h000
`define AWG_OFF_DOUT 12'h004
`define AWG_OFF_DIR 12'h008
`define AWG_OFF_DIN 12'h00C
`define AWG_OFF_WEN 12'h010
`define AWG_OFF_STAT 12'h014
`define AWG_OFF_MASK 12'h018
`define AWG_OFF_CMD 12'h01C
`define AWG_OFF_CH_BASE 12'h040
`define AWG_CH_STRIDE_LSB 3
`define AWG_CTRL_CLKEN 0
`define AWG_CMD_START 0
`define AWG_CMD_STOP 1
`endif

// file: awg_pkg.sv
`default_nettype none
package awg_pkg;
	typedef enum logic [1:0] {
		AWG_IDLE,
		AWG_HIGH,
		AWG_LOW
	} awg_state_type;
endpackage
`default_nettype wire

// file: awg_chan_if.sv
`default_nettype none
interface awg_chan_if #(parameter int CNT_W = 16);
	logic clk_en;
	logic run;
	logic restart;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] high;
	logic wave;
	logic wrap;
	modport ctrl (output clk_en, output run, output restart, output period, output high,
		input wave, input wrap);
	modport chan (input clk_en, input run, input restart, input period, input high,
		output wave, output wrap);
endinterface
`default_nettype wire

// file: awg_channel.sv
`include "awg_regs.svh"
`default_nettype none
module awg_channel
	import awg_pkg::*;
#(
	parameter int CNT_W = 16
)(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	awg_chan_if.chan ch
);
	awg_state_type state_q;
	logic [CNT_W-1:0] cnt_q;
	logic wave_q;
	logic wrap_q;
	wire last_w = (cnt_q >= ch.period - CNT_W'(1));
	wire high_w = (cnt_q < ch.high);
	// The counter only advances while the gated clock enable is on, so a stopped port holds its state unless run drops or a restart clears it.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_q <= AWG_IDLE;
			cnt_q <= '0;
			wave_q <= 1'b0;
			wrap_q <= 1'b0;
		end
		else
		begin
			wrap_q <= 1'b0;
			case (state_q)
				AWG_IDLE:
				begin
					cnt_q <= '0;
					wave_q <= 1'b0;
					if (ch.run && ch.clk_en)
						state_q <= AWG_HIGH;
				end
				AWG_HIGH, AWG_LOW:
				begin
					if (!ch.run || ch.restart)
					begin
						state_q <= ch.run ? AWG_HIGH : AWG_IDLE; // [RL11]
						cnt_q <= '0;
						wave_q <= 1'b0;
					end
					else if (ch.clk_en)
					begin
						wave_q <= high_w; // [RL6] [RL3]
						state_q <= high_w ? AWG_HIGH : AWG_LOW;
						if (last_w)
						begin
							cnt_q <= '0; // [RL11]
							wrap_q <= 1'b1;
						end
						else
							cnt_q <= cnt_q + CNT_W'(1);
					end
				end
				default: state_q <= AWG_IDLE;
			endcase
		end
	end
	assign ch.wave = wave_q;
	assign ch.wrap = wrap_q;
	a_wrap_restarts: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		wrap_q |-> cnt_q == '0) else $error("wrap without counter reload"); // [RL11]
endmodule
`default_nettype wire

// file: awg_actuator_model.sv
`default_nettype none
module awg_actuator_model
(
	input wire logic [7:0] drive_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] feedback_i,
	output logic [7:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released pins show the actuator's own feedback level, never the last driven value.
	assign level_o = (oe_i & drive_i) | (~oe_i & feedback_i);
endmodule
`default_nettype wire

// file: tb_actuator_waveform_gpio.sv
`include "awg_regs.svh"
`default_nettype none
module tb_actuator_waveform_gpio;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] feedback = 8'h00;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic hresp_o;
	logic [7:0] pin_o;
	logic [7:0] pin_oe_o;
	logic [7:0] pin_level;
	logic port_clk_en_o;
	logic irq_o;
	int errors = 0;
	int cmp_count = 0;
	awg_top u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .hsel_i(1'b1),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pin_i(pin_level), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .port_clk_en_o(port_clk_en_o), .irq_o(irq_o));
	awg_actuator_model u_act (.drive_i(pin_o), .oe_i(pin_oe_o), .feedback_i(feedback),
		.level_o(pin_level));
	initial
	begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic rdy;
		@(posedge ref_clk_i);
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do
		begin
			@(negedge ref_clk_i);
			r = hrdata_o;
			rdy = hreadyout_o;
			@(posedge ref_clk_i);
		end while (rdy !== 1'b1);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask
	task automatic toggles(input int n, output int t);
		logic p;
		t = 0;
		@(negedge ref_clk_i);
		p = pin_o[0];
		repeat (n)
		begin
			@(negedge ref_clk_i);
			if (pin_o[0] !== p)
				t++;
			p = pin_o[0];
		end
	endtask
	task automatic t_reset();
		chk({24'h0, pin_oe_o}, 32'h0);
		rd_chk(`AWG_OFF_DIR, 32'h0);
		chk({31'h0, port_clk_en_o}, 32'h0);
		rd_chk(12'h0FC, 32'h0);
		chk({30'h0, hresp_o, hreadyout_o}, 32'h1);
	endtask
	task automatic t_dout();
		wr(`AWG_OFF_DIR, 32'h000000FF);
		wr(`AWG_OFF_DOUT, 32'h000000A5);
		repeat (2) @(negedge ref_clk_i);
		chk({pin_oe_o, pin_o}, 32'h0000FFA5);
		wr(`AWG_OFF_DOUT, 32'h0000005A);
		repeat (2) @(negedge ref_clk_i);
		chk({24'h0, pin_o}, 32'h0000005A);
	endtask
	task automatic t_din();
		feedback <= 8'h3C;
		wr(`AWG_OFF_DIR, 32'h0000000F);
		repeat (3) @(posedge ref_clk_i);
		rd_chk(`AWG_OFF_DIN, 32'h0000003A);
		feedback <= 8'hC3;
		repeat (3) @(posedge ref_clk_i);
		rd_chk(`AWG_OFF_DIN, 32'h000000CA);
	endtask
	task automatic t_wave();
		int t;
		wr(`AWG_OFF_DIR, 32'h000000FF);
		wr(`AWG_OFF_DOUT, 32'h0);
		wr(`AWG_OFF_CTRL, 32'h1);
		@(negedge ref_clk_i);
		chk({31'h0, port_clk_en_o}, 32'h1);
		wr(`AWG_OFF_WEN, 32'h1);
		wr(`AWG_OFF_CH_BASE, 32'h2);
		wr(`AWG_OFF_CH_BASE + 12'h004, 32'h1);
		wr(`AWG_OFF_MASK, 32'h1);
		wr(`AWG_OFF_CMD, 32'h00000101);
		repeat (4) @(posedge ref_clk_i);
		toggles(8, t);
		chk(32'(t), 32'h8);
		rd_chk(`AWG_OFF_STAT, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		wr(`AWG_OFF_MASK, 32'h0);
		@(negedge ref_clk_i);
		chk({31'h0, irq_o}, 32'h0);
		rd_chk(`AWG_OFF_CMD, 32'h00000100);
		wr(`AWG_OFF_CMD, 32'h00000102);
		wr(`AWG_OFF_STAT, 32'h1);
		rd_chk(`AWG_OFF_STAT, 32'h0);
		rd_chk(`AWG_OFF_CMD, 32'h0);
		chk({24'h0, pin_o}, 32'h0);
		wr(`AWG_OFF_CTRL, 32'h0);
		wr(`AWG_OFF_CMD, 32'h00000101);
		repeat (4) @(posedge ref_clk_i);
		toggles(8, t);
		chk(32'(t), 32'h0);
		chk({31'h0, port_clk_en_o}, 32'h0);
	endtask
	task automatic results();
		$display("mismatches %0d of %0d comparisons", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#100us;
		errors++;
		results();
	end
	initial
	begin
		repeat (12) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_dout();
		t_din();
		t_wave();
		results();
	end
endmodule
`default_nettype wire
